// [albx_exec.v]
// execution unit: arithmetic, logic, multiply, jumps, skips and branches
// Notes on behaviour
// - add, add-with-carry: flags ZCNVH, one cycle
// - subtract forms with borrow: ZCNVH, one cycle
// - word immediate add/subtract: ZCNVS, two cycles
// - and/or/xor: only Z N V S, one cycle
// - invert and negate with their flags
// - set/clear mask bits, Z N V
// - increment/decrement keep carry untouched
// - test, clear, load ones; ones keeps flags
// - multiplies into pair, Z C, two cycles
// - fractional multiply shifts product left one
// - relative jump: pc plus offset plus one
// - indirect two cycles, direct three cycles
// - calls push return; returns pop, four cycles
// - compares set flags without writing back
// - skip when registers are equal
// - skip on general register bit value
// - skip on io register bit value
// - branch on chosen status bit match
// - named branches ge/lt decide on two flags, N and V
// - signed branches use N xor V
`timescale 1ns/1ps
`default_nettype none
`include "albx_map.vh"
module albx_exec #(
  parameter PC_W = 16
) (
  input wire clk_sys,
  input wire reset,
  input wire start,
  input wire [5:0] op,
  input wire [7:0] rd_val,
  input wire [7:0] rr_val,
  input wire [7:0] rd_hi_val,
  input wire [7:0] imm,
  input wire use_imm,
  input wire [2:0] bit_sel,
  input wire [7:0] io_val,
  input wire [PC_W-1:0] pc_in,
  input wire [PC_W-1:0] target,
  input wire [PC_W-1:0] z_ptr,
  input wire [PC_W-1:0] stack_pc,
  input wire next_two_word,
  input wire [7:0] status_flags_register_in,
  output wire busy,
  output reg done_r,
  output reg [7:0] res_lo_r,
  output reg [7:0] res_hi_r,
  output reg wr_lo_r,
  output reg wr_hi_r,
  output reg wr_pair01_r,
  output reg [7:0] status_flags_register_r,
  output reg [PC_W-1:0] pc_r,
  output reg pc_load_r,
  output reg push_r,
  output reg pop_r,
  output reg [PC_W-1:0] ret_addr_r
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  reg state_r;
  reg [2:0] cnt_r;
  reg [2:0] cyc_nxt;
  reg [7:0] lo_nxt;
  reg [7:0] hi_nxt;
  reg wlo_nxt;
  reg whi_nxt;
  reg wpair_nxt;
  reg [7:0] status_flags_register_nxt;
  reg [PC_W-1:0] pc_nxt;
  reg pcl_nxt;
  reg push_nxt;
  reg pop_nxt;
  reg [7:0] opb;
  reg [8:0] sum9;
  reg [15:0] w16;
  reg [15:0] pair;
  reg cin;
  reg take;
  reg m_as;
  reg m_bs;
  reg m_fr;
  wire [15:0] m_prod;
  wire m_c;
  wire m_z;
  wire [PC_W-1:0] rel_tgt;
  wire [PC_W-1:0] seq_pc;

  // shared flag helper for 8-bit add/sub; v and h per two's complement rules
  function [7:0] flags8;
    input [7:0] s_in;
    input [7:0] d;
    input [7:0] r;
    input [7:0] res;
    input sub;
    input keep_z;
    input upd_ch;
    reg [7:0] f;
    reg c;
    reg h;
    reg v;
    begin
      f = s_in;
      if (sub)
      begin
        c = (~d[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~d[7]);
        h = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
        v = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
      end
      else
      begin
        c = (d[7] & r[7]) | (r[7] & ~res[7]) | (~res[7] & d[7]);
        h = (d[3] & r[3]) | (r[3] & ~res[3]) | (~res[3] & d[3]);
        v = (d[7] & r[7] & ~res[7]) | (~d[7] & ~r[7] & res[7]);
      end
      // borrow forms keep z set only if it was already set
      f[`ALBX_F_Z] = keep_z ? ((res == `ALBX_ALL_ZERO) & s_in[`ALBX_F_Z]) : (res == `ALBX_ALL_ZERO);
      f[`ALBX_F_N] = res[7];
      f[`ALBX_F_V] = v;
      f[`ALBX_F_S] = res[7] ^ v;
      if (upd_ch)
      begin
        f[`ALBX_F_C] = c;
        f[`ALBX_F_H] = h;
      end
      flags8 = f;
    end
  endfunction

  // logical result flags: v cleared, c and h untouched
  function [7:0] flags_log;
    input [7:0] s_in;
    input [7:0] res;
    reg [7:0] f;
    begin
      f = s_in;
      f[`ALBX_F_Z] = (res == `ALBX_ALL_ZERO);
      f[`ALBX_F_N] = res[7];
      f[`ALBX_F_V] = 1'b0;
      f[`ALBX_F_S] = res[7];
      flags_log = f;
    end
  endfunction

  albx_mul u_mul (
    .a(rd_val),
    .b(rr_val),
    .a_signed(m_as),
    .b_signed(m_bs),
    .frac(m_fr),
    .prod(m_prod),
    .carry(m_c),
    .zero(m_z)
  );

  // offset is the immediate sign-extended to the counter width
  assign rel_tgt = pc_in + {{(PC_W-8){imm[7]}}, imm} + {{(PC_W-1){1'b0}}, 1'b1};
  assign seq_pc = pc_in + {{(PC_W-1){1'b0}}, 1'b1};
  // new operations are refused while a multi-cycle one drains
  assign busy = (state_r == ST_WAIT);

  // decode and compute the whole effect in the issue cycle
  always @*
  begin
    opb = use_imm ? imm : rr_val;
    lo_nxt = res_lo_r;
    hi_nxt = res_hi_r;
    wlo_nxt = 1'b0;
    whi_nxt = 1'b0;
    wpair_nxt = 1'b0;
    // untouched flags follow the incoming status, not the last result
    status_flags_register_nxt = status_flags_register_in;
    pc_nxt = pc_r;
    pcl_nxt = 1'b0;
    push_nxt = 1'b0;
    pop_nxt = 1'b0;
    cyc_nxt = `ALBX_CYC_1;
    sum9 = 9'h000;
    w16 = 16'h0000;
    pair = {rd_hi_val, rd_val};
    cin = status_flags_register_in[`ALBX_F_C];
    take = 1'b0;
    m_as = (op == `ALBX_OP_MUL_SS) || (op == `ALBX_OP_MUL_SU) ||
           (op == `ALBX_OP_FRACTIONAL_PRODUCT_SS) || (op == `ALBX_OP_FRACTIONAL_PRODUCT_SU);
    m_bs = (op == `ALBX_OP_MUL_SS) || (op == `ALBX_OP_FRACTIONAL_PRODUCT_SS);
    m_fr = (op == `ALBX_OP_FRACTIONAL_PRODUCT_UU) || (op == `ALBX_OP_FRACTIONAL_PRODUCT_SS) || (op == `ALBX_OP_FRACTIONAL_PRODUCT_SU);
    case (op)
      `ALBX_OP_SUM, `ALBX_OP_SUM_C:
      begin
        sum9 = {1'b0, rd_val} + {1'b0, opb} + {8'h00, (op == `ALBX_OP_SUM_C) & cin};
        lo_nxt = sum9[7:0];
        wlo_nxt = 1'b1;
        status_flags_register_nxt = flags8(status_flags_register_in, rd_val, opb, sum9[7:0], 1'b0, 1'b0, 1'b1);
      end
      `ALBX_OP_DIFF, `ALBX_OP_DIFF_B, `ALBX_OP_CMP, `ALBX_OP_CMP_C:
      begin
        sum9 = {1'b0, rd_val} - {1'b0, opb} - {8'h00, ((op == `ALBX_OP_DIFF_B) | (op == `ALBX_OP_CMP_C)) & cin};
        lo_nxt = sum9[7:0];
        wlo_nxt = (op == `ALBX_OP_DIFF) | (op == `ALBX_OP_DIFF_B);
        status_flags_register_nxt = flags8(status_flags_register_in, rd_val, opb, sum9[7:0], 1'b1,
                          (op == `ALBX_OP_DIFF_B) | (op == `ALBX_OP_CMP_C), 1'b1);
      end
      `ALBX_OP_WSUM, `ALBX_OP_WMINUS:
      begin
        w16 = (op == `ALBX_OP_WSUM) ? pair + {8'h00, imm} : pair - {8'h00, imm};
        lo_nxt = w16[7:0];
        hi_nxt = w16[15:8];
        wlo_nxt = 1'b1;
        whi_nxt = 1'b1;
        cyc_nxt = `ALBX_CYC_2;
        status_flags_register_nxt[`ALBX_F_Z] = (w16 == 16'h0000);
        status_flags_register_nxt[`ALBX_F_N] = w16[15];
        status_flags_register_nxt[`ALBX_F_V] = (op == `ALBX_OP_WSUM) ? (~pair[15] & w16[15]) : (pair[15] & ~w16[15]);
        status_flags_register_nxt[`ALBX_F_C] = (op == `ALBX_OP_WSUM) ? (pair[15] & ~w16[15]) : (~pair[15] & w16[15]);
        status_flags_register_nxt[`ALBX_F_S] = w16[15] ^ status_flags_register_nxt[`ALBX_F_V];
      end
      // bitwise ops; mask set/clear and test/clear map here
      `ALBX_OP_AND, `ALBX_OP_OR, `ALBX_OP_XOR:
      begin
        if (op == `ALBX_OP_AND)
          lo_nxt = rd_val & opb;
        else if (op == `ALBX_OP_OR)
          lo_nxt = rd_val | opb;
        else
          lo_nxt = rd_val ^ opb;
        wlo_nxt = 1'b1;
        status_flags_register_nxt = flags_log(status_flags_register_in, lo_nxt);
      end
      `ALBX_OP_INVERT:
      begin
        lo_nxt = `ALBX_ALL_ONES - rd_val;
        wlo_nxt = 1'b1;
        status_flags_register_nxt = flags_log(status_flags_register_in, lo_nxt);
        status_flags_register_nxt[`ALBX_F_C] = 1'b1;
      end
      `ALBX_OP_NEGATE:
      begin
        lo_nxt = `ALBX_ALL_ZERO - rd_val;
        wlo_nxt = 1'b1;
        status_flags_register_nxt = flags8(status_flags_register_in, `ALBX_ALL_ZERO, rd_val, lo_nxt, 1'b1, 1'b0, 1'b1);
      end
      `ALBX_OP_INC, `ALBX_OP_DEC:
      begin
        lo_nxt = (op == `ALBX_OP_INC) ? rd_val + 8'h01 : rd_val - 8'h01;
        wlo_nxt = 1'b1;
        status_flags_register_nxt = flags8(status_flags_register_in, rd_val, 8'h01, lo_nxt, op == `ALBX_OP_DEC, 1'b0, 1'b0);
      end
      `ALBX_OP_ONES:
      begin
        lo_nxt = `ALBX_ALL_ONES;
        wlo_nxt = 1'b1;
      end
      // product into pair; fractional shift inside multiplier
      `ALBX_OP_MUL_UU, `ALBX_OP_MUL_SS, `ALBX_OP_MUL_SU,
      `ALBX_OP_FRACTIONAL_PRODUCT_UU, `ALBX_OP_FRACTIONAL_PRODUCT_SS, `ALBX_OP_FRACTIONAL_PRODUCT_SU:
      begin
        lo_nxt = m_prod[7:0];
        hi_nxt = m_prod[15:8];
        wpair_nxt = 1'b1;
        cyc_nxt = `ALBX_CYC_2;
        status_flags_register_nxt[`ALBX_F_Z] = m_z;
        status_flags_register_nxt[`ALBX_F_C] = m_c;
      end
      `ALBX_OP_RGOTO:
      begin
        pc_nxt = rel_tgt;
        pcl_nxt = 1'b1;
        cyc_nxt = `ALBX_CYC_2;
      end
      `ALBX_OP_IGOTO, `ALBX_OP_DGOTO:
      begin
        pc_nxt = (op == `ALBX_OP_IGOTO) ? z_ptr : target;
        pcl_nxt = 1'b1;
        cyc_nxt = (op == `ALBX_OP_IGOTO) ? `ALBX_CYC_2 : `ALBX_CYC_3;
      end
      `ALBX_OP_RINVOKE, `ALBX_OP_IINVOKE, `ALBX_OP_DINVOKE:
      begin
        pc_nxt = (op == `ALBX_OP_RINVOKE) ? rel_tgt : (op == `ALBX_OP_IINVOKE) ? z_ptr : target;
        pcl_nxt = 1'b1;
        push_nxt = 1'b1;
        cyc_nxt = (op == `ALBX_OP_DINVOKE) ? `ALBX_CYC_4 : `ALBX_CYC_3;
      end
      // returns; interrupt return also re-enables interrupts
      `ALBX_OP_SUB_BACK, `ALBX_OP_INT_BACK:
      begin
        pc_nxt = stack_pc;
        pcl_nxt = 1'b1;
        pop_nxt = 1'b1;
        cyc_nxt = `ALBX_CYC_4;
        if (op == `ALBX_OP_INT_BACK)
          status_flags_register_nxt[`ALBX_F_I] = 1'b1;
      end
      `ALBX_OP_SKIP_EQ, `ALBX_OP_SKIP_RBC, `ALBX_OP_SKIP_RBS, `ALBX_OP_SKIP_IOC, `ALBX_OP_SKIP_IOS:
      begin
        if (op == `ALBX_OP_SKIP_EQ)
          take = (rd_val == rr_val);
        else if (op == `ALBX_OP_SKIP_RBC)
          take = ~rr_val[bit_sel];
        else if (op == `ALBX_OP_SKIP_RBS)
          take = rr_val[bit_sel];
        else if (op == `ALBX_OP_SKIP_IOC)
          take = ~io_val[bit_sel];
        else
          take = io_val[bit_sel];
        pcl_nxt = 1'b1;
        if (!take)
        begin
          pc_nxt = seq_pc;
          cyc_nxt = `ALBX_CYC_1;
        end
        else if (next_two_word)
        begin
          pc_nxt = pc_in + {{(PC_W-2){1'b0}}, 2'h3};
          cyc_nxt = `ALBX_CYC_3;
        end
        else
        begin
          pc_nxt = pc_in + {{(PC_W-2){1'b0}}, 2'h2};
          cyc_nxt = `ALBX_CYC_2;
        end
      end
      `ALBX_OP_BR_SET, `ALBX_OP_BR_CLR, `ALBX_OP_BR_GE, `ALBX_OP_BR_LT:
      begin
        if (op == `ALBX_OP_BR_SET)
          take = status_flags_register_in[bit_sel];
        else if (op == `ALBX_OP_BR_CLR)
          take = ~status_flags_register_in[bit_sel];
        else if (op == `ALBX_OP_BR_GE)
          take = ~(status_flags_register_in[`ALBX_F_N] ^ status_flags_register_in[`ALBX_F_V]);
        else
          take = status_flags_register_in[`ALBX_F_N] ^ status_flags_register_in[`ALBX_F_V];
        pcl_nxt = 1'b1;
        pc_nxt = take ? rel_tgt : seq_pc;
        cyc_nxt = take ? `ALBX_CYC_2 : `ALBX_CYC_1;
      end
      default:
      begin
        status_flags_register_nxt = status_flags_register_in;
      end
    endcase
  end

  // results land the cycle after issue; done marks the last cycle
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      done_r <= 1'b0;
      res_lo_r <= 8'h00;
      res_hi_r <= 8'h00;
      wr_lo_r <= 1'b0;
      wr_hi_r <= 1'b0;
      wr_pair01_r <= 1'b0;
      status_flags_register_r <= 8'h00;
      pc_r <= {PC_W{1'b0}};
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      pop_r <= 1'b0;
      ret_addr_r <= {PC_W{1'b0}};
    end
    else
    begin
      wr_lo_r <= 1'b0;
      wr_hi_r <= 1'b0;
      wr_pair01_r <= 1'b0;
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      pop_r <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            res_lo_r <= lo_nxt;
            res_hi_r <= hi_nxt;
            wr_lo_r <= wlo_nxt;
            wr_hi_r <= whi_nxt;
            wr_pair01_r <= wpair_nxt;
            status_flags_register_r <= status_flags_register_nxt;
            pc_r <= pc_nxt;
            pc_load_r <= pcl_nxt;
            push_r <= push_nxt;
            pop_r <= pop_nxt;
            // direct calls are two words long
            ret_addr_r <= (op == `ALBX_OP_DINVOKE) ? pc_in + {{(PC_W-2){1'b0}}, 2'h2} : seq_pc;
            if (cyc_nxt == `ALBX_CYC_1)
              done_r <= 1'b1;
            else
            begin
              state_r <= ST_WAIT;
              cnt_r <= cyc_nxt - 3'h1;
            end
          end
        end
        ST_WAIT:
        begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1)
          begin
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [albx_exec_monitor.sv]
// port-level checker for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "albx_map.vh"
module albx_monitor #(
  parameter PC_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic [5:0] op,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm,
  input wire logic use_imm,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic next_two_word,
  input wire logic [7:0] status_flags_register_in,
  input wire logic busy,
  input wire logic done_r,
  input wire logic [7:0] res_lo_r,
  input wire logic [7:0] res_hi_r,
  input wire logic wr_lo_r,
  input wire logic wr_hi_r,
  input wire logic wr_pair01_r,
  input wire logic [7:0] status_flags_register_r,
  input wire logic [PC_W-1:0] pc_r,
  input wire logic pc_load_r,
  input wire logic push_r,
  input wire logic pop_r,
  input wire logic [PC_W-1:0] ret_addr_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // expected values formed from the inputs of the taking edge
  wire go = start && !busy;
  wire c_in = status_flags_register_in[`ALBX_F_C];
  wire [7:0] add_w = rd_val + rr_val;
  wire [15:0] mul_w = rd_val * rr_val;
  wire [PC_W-1:0] rel_w = pc_in + {{(PC_W-8){imm[7]}}, imm} + 1'b1;
  wire [PC_W-1:0] seq_w = pc_in + 1'b1;
  AST_SUM_RES: assert property (go && op == `ALBX_OP_SUM && !use_imm |=> done_r && wr_lo_r && res_lo_r == $past(add_w))
    else $error("sum result or timing wrong");
  AST_WSUM_TWO: assert property (go && op == `ALBX_OP_WSUM |=> wr_lo_r && wr_hi_r && !done_r ##1 done_r)
    else $error("word sum not two cycles");
  AST_INC_KEEP_C: assert property (go && op == `ALBX_OP_INC |=> status_flags_register_r[`ALBX_F_C] == $past(c_in))
    else $error("increment changed carry");
  AST_ONES_FLAGS: assert property (go && op == `ALBX_OP_ONES |=> res_lo_r == 8'hFF && status_flags_register_r == $past(status_flags_register_in))
    else $error("all ones load wrong");
  AST_MUL_PAIR: assert property (go && op == `ALBX_OP_MUL_UU |=> wr_pair01_r && {res_hi_r, res_lo_r} == $past(mul_w) ##1 done_r)
    else $error("unsigned product wrong");
  AST_RGOTO_PC: assert property (go && op == `ALBX_OP_RGOTO |=> pc_load_r && pc_r == $past(rel_w))
    else $error("relative jump target wrong");
  AST_DCALL_FOUR: assert property (go && op == `ALBX_OP_DINVOKE |=> (push_r && !done_r) ##1 (!done_r)[*2] ##1 done_r)
    else $error("direct call timing wrong");
  AST_CALL_RET: assert property (go && op == `ALBX_OP_RINVOKE |=> push_r && busy && ret_addr_r == $past(seq_w))
    else $error("call return address wrong");
  AST_BACK_POP: assert property (go && op == `ALBX_OP_SUB_BACK |=> pop_r && busy && !push_r)
    else $error("return did not pop");
  AST_CMP_NOWRITE: assert property (go && op == `ALBX_OP_CMP |=> !wr_lo_r && !wr_hi_r && done_r)
    else $error("compare wrote a register");
  AST_SKIP_TWO_WORD: assert property (go && op == `ALBX_OP_SKIP_EQ && rd_val == rr_val && next_two_word
    |=> pc_r == PC_W'($past(pc_in) + 3) ##2 done_r)
    else $error("equal skip over two words wrong");
  AST_BGE_TAKEN: assert property (go && op == `ALBX_OP_BR_GE && status_flags_register_in[2] == status_flags_register_in[3] |=> pc_r == $past(rel_w) ##1 done_r)
    else $error("signed ge branch wrong");
endmodule
bind albx_exec albx_monitor #(.PC_W(PC_W)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .start(start), .op(op), .rd_val(rd_val), .rr_val(rr_val),
  .imm(imm), .use_imm(use_imm), .pc_in(pc_in), .next_two_word(next_two_word), .status_flags_register_in(status_flags_register_in),
  .busy(busy), .done_r(done_r), .res_lo_r(res_lo_r), .res_hi_r(res_hi_r), .wr_lo_r(wr_lo_r),
  .wr_hi_r(wr_hi_r), .wr_pair01_r(wr_pair01_r), .status_flags_register_r(status_flags_register_r), .pc_r(pc_r), .pc_load_r(pc_load_r),
  .push_r(push_r), .pop_r(pop_r), .ret_addr_r(ret_addr_r)
);
`default_nettype wire

// [albx_map.vh]
// operation codes, flag positions and cycle counts for the execution block
`ifndef ALBX_MAP_VH
`define ALBX_MAP_VH
`define ALBX_OP_SUM 6'h00
`define ALBX_OP_SUM_C 6'h01
`define ALBX_OP_DIFF 6'h02
`define ALBX_OP_DIFF_B 6'h03
`define ALBX_OP_WSUM 6'h04
`define ALBX_OP_WMINUS 6'h05
`define ALBX_OP_AND 6'h06
`define ALBX_OP_OR 6'h07
`define ALBX_OP_XOR 6'h08
`define ALBX_OP_INVERT 6'h09
`define ALBX_OP_NEGATE 6'h0A
`define ALBX_OP_INC 6'h0B
`define ALBX_OP_DEC 6'h0C
`define ALBX_OP_ONES 6'h0D
`define ALBX_OP_MUL_UU 6'h0E
`define ALBX_OP_MUL_SS 6'h0F
`define ALBX_OP_MUL_SU 6'h10
`define ALBX_OP_FRACTIONAL_PRODUCT_UU 6'h11
`define ALBX_OP_FRACTIONAL_PRODUCT_SS 6'h12
`define ALBX_OP_FRACTIONAL_PRODUCT_SU 6'h13
`define ALBX_OP_RGOTO 6'h14
`define ALBX_OP_IGOTO 6'h15
`define ALBX_OP_DGOTO 6'h16
`define ALBX_OP_RINVOKE 6'h17
`define ALBX_OP_IINVOKE 6'h18
`define ALBX_OP_DINVOKE 6'h19
`define ALBX_OP_SUB_BACK 6'h1A
`define ALBX_OP_INT_BACK 6'h1B
`define ALBX_OP_CMP 6'h1C
`define ALBX_OP_CMP_C 6'h1D
`define ALBX_OP_SKIP_EQ 6'h1E
`define ALBX_OP_SKIP_RBC 6'h1F
`define ALBX_OP_SKIP_RBS 6'h20
`define ALBX_OP_SKIP_IOC 6'h21
`define ALBX_OP_SKIP_IOS 6'h22
`define ALBX_OP_BR_SET 6'h23
`define ALBX_OP_BR_CLR 6'h24
`define ALBX_OP_BR_GE 6'h25
`define ALBX_OP_BR_LT 6'h26
`define ALBX_F_C 0
`define ALBX_F_Z 1
`define ALBX_F_N 2
`define ALBX_F_V 3
`define ALBX_F_S 4
`define ALBX_F_H 5
`define ALBX_F_T 6
`define ALBX_F_I 7
`define ALBX_CYC_1 3'h1
`define ALBX_CYC_2 3'h2
`define ALBX_CYC_3 3'h3
`define ALBX_CYC_4 3'h4
`define ALBX_ALL_ONES 8'hFF
`define ALBX_ALL_ZERO 8'h00
`endif

// [albx_mul.v]
// signed/unsigned/fractional 8x8 multiplier with flag outputs
`timescale 1ns/1ps
`default_nettype none
module albx_mul (
  input wire [7:0] a,
  input wire [7:0] b,
  input wire a_signed,
  input wire b_signed,
  input wire frac,
  output reg [15:0] prod,
  output reg carry,
  output reg zero
);
  reg [17:0] ext_a;
  reg [17:0] ext_b;
  reg [35:0] full;
  reg [15:0] raw;
  // sign-extend per operand, then optional left shift
  always @*
  begin
    ext_a = a_signed ? {{10{a[7]}}, a} : {10'h000, a};
    ext_b = b_signed ? {{10{b[7]}}, b} : {10'h000, b};
    full = ext_a * ext_b;
    raw = full[15:0];
    carry = raw[15];
    prod = frac ? {raw[14:0], 1'b0} : raw;
    zero = (prod == 16'h0000);
  end
endmodule
`default_nettype wire

// [tb_arith_logic_branch_exec.sv]
// self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "albx_map.vh"
module tb_arith_logic_branch_exec;
  logic clk_sys = 0, reset = 1, start = 0, use_imm = 0, next_two_word = 0;
  logic [5:0] op = 0;
  logic [7:0] rd_val = 0, rr_val = 0, rd_hi_val = 0, imm = 0, io_val = 0, status_flags_register_in = 0;
  logic [2:0] bit_sel = 0;
  logic [15:0] pc_in = 0, target = 0, z_ptr = 0, stack_pc = 0;
  wire busy, done_r, wr_lo_r, wr_hi_r, wr_pair01_r, pc_load_r, push_r, pop_r;
  wire [7:0] res_lo_r, res_hi_r, status_flags_register_r;
  wire [15:0] pc_r, ret_addr_r;
  typedef struct {logic [1:0] kd; logic [15:0] v; logic [7:0] m; logic [7:0] f;} albx_note_t;
  albx_note_t q[$];
  albx_note_t nt;
  int n_fail = 0, samples_checked = 0, j;
  logic [7:0] a, b, h, k, s, io, o2, y;
  logic ui, tw, cd;
  logic [2:0] bs;
  logic [15:0] pc, tg, zp, sp, rl, w, x, p;
  logic [16:0] t;
  albx_exec #(.PC_W(16)) DUT (
    .clk_sys(clk_sys), .reset(reset), .start(start), .op(op), .rd_val(rd_val), .rr_val(rr_val),
    .rd_hi_val(rd_hi_val), .imm(imm), .use_imm(use_imm), .bit_sel(bit_sel), .io_val(io_val),
    .pc_in(pc_in), .target(target), .z_ptr(z_ptr), .stack_pc(stack_pc), .next_two_word(next_two_word),
    .status_flags_register_in(status_flags_register_in), .busy(busy), .done_r(done_r), .res_lo_r(res_lo_r), .res_hi_r(res_hi_r),
    .wr_lo_r(wr_lo_r), .wr_hi_r(wr_hi_r), .wr_pair01_r(wr_pair01_r), .status_flags_register_r(status_flags_register_r), .pc_r(pc_r),
    .pc_load_r(pc_load_r), .push_r(push_r), .pop_r(pop_r), .ret_addr_r(ret_addr_r)
  );
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // issue one op, note its result, then count cycles up to done (bounded)
  task automatic run(logic [5:0] o, logic [1:0] kd, logic [15:0] v, logic [7:0] m, logic [7:0] f, int n);
    int c;
    q.push_back('{kd, v, m, f & m});
    @(posedge clk_sys);
    start <= 1;
    op <= o;
    rd_val <= a;
    rr_val <= b;
    rd_hi_val <= h;
    imm <= k;
    use_imm <= ui;
    bit_sel <= bs;
    io_val <= io;
    status_flags_register_in <= s;
    next_two_word <= tw;
    pc_in <= pc;
    target <= tg;
    z_ptr <= zp;
    stack_pc <= sp;
    @(posedge clk_sys);
    start <= 0;
    c = 1;
    #1;
    while (done_r !== 1'b1 && c < 8)
    begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk("cycles", 16'(n), 16'(c));
    if (c >= 8)
      conclude();
  endtask
  // flags of an 8-bit add or subtract; borrow forms may keep a prior zero
  function automatic logic [15:0] ar(logic [7:0] d, logic [7:0] r, logic sb, logic ci, logic kz);
    logic [8:0] u;
    logic [7:0] z;
    logic hc, v;
    u = sb ? {1'b0, d} - r - ci : d + r + ci;
    z = u[7:0];
    hc = sb ? (~d[3] & r[3]) | (r[3] & z[3]) | (z[3] & ~d[3]) : (d[3] & r[3]) | (r[3] & ~z[3]) | (~z[3] & d[3]);
    v = sb ? (d[7] ^ r[7]) & (d[7] ^ z[7]) : ~(d[7] ^ r[7]) & (d[7] ^ z[7]);
    return {s[7:6], hc, z[7] ^ v, v, z[7], z == 8'h00 && (!kz || s[1]), u[8], z};
  endfunction
  // scoreboard: oldest note against the held outputs when done shows
  always @(posedge clk_sys)
    if (!reset && done_r === 1'b1 && q.size() > 0)
    begin
      nt = q.pop_front();
      if (nt.kd == 0)
        chk("result", nt.v, {8'h00, res_lo_r});
      if (nt.kd == 1)
        chk("pair", nt.v, {res_hi_r, res_lo_r});
      if (nt.kd == 2)
        chk("pc", nt.v, pc_r);
      chk("flags", {8'h00, nt.f}, {8'h00, status_flags_register_r & nt.m});
    end
  // main sequence: random operands, every op code each round
  initial
  begin
    p = 16'($urandom(32'hAEB8));
    repeat (12) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    #1;
    chk("reset", 16'h0000, {res_lo_r, status_flags_register_r});
    for (int i = 0; i < 40; i++)
    begin
      {a, b, h, k, s, io} = 48'({$urandom, $urandom});
      {pc, tg, zp, sp} = {$urandom, $urandom};
      {tw, bs} = 4'($urandom);
      if (i % 2 == 1)
        b = a;
      ui = 0;
      rl = pc + {{8{k[7]}}, k} + 16'h0001;
      x = ar(a, b, 0, 0, 0);
      run(`ALBX_OP_SUM, 0, x[7:0], 8'h2F, x[15:8], 1);
      x = ar(a, b, 0, s[0], 0);
      run(`ALBX_OP_SUM_C, 0, x[7:0], 8'h2D, x[15:8], 1);
      ui = 1'($urandom);
      o2 = ui ? k : b;
      x = ar(a, o2, 1, 0, 0);
      run(`ALBX_OP_DIFF, 0, x[7:0], 8'h2F, x[15:8], 1);
      run(`ALBX_OP_CMP, 3, 16'h0000, 8'h2F, x[15:8], 1);
      x = ar(a, o2, 1, s[0], 1);
      run(`ALBX_OP_DIFF_B, 0, x[7:0], 8'h2F, x[15:8], 1);
      run(`ALBX_OP_CMP_C, 3, 16'h0000, 8'h2F, x[15:8], 1);
      for (j = 0; j < 3; j++)
      begin
        y = j == 0 ? a & o2 : j == 1 ? a | o2 : a ^ o2;
        run(6'(`ALBX_OP_AND + j), 0, y, 8'h0E, {5'h00, y[7], y == 8'h00, 1'b0}, 1);
      end
      y = ~a;
      run(`ALBX_OP_INVERT, 0, y, 8'h0F, {5'h00, y[7], y == 8'h00, 1'b1}, 1);
      x = ar(8'h00, a, 1, 0, 0);
      run(`ALBX_OP_NEGATE, 0, x[7:0], 8'h2F, x[15:8], 1);
      x = ar(a, 8'h01, 0, 0, 0);
      run(`ALBX_OP_INC, 0, x[7:0], 8'h0F, {x[15:9], s[0]}, 1);
      x = ar(a, 8'h01, 1, 0, 0);
      run(`ALBX_OP_DEC, 0, x[7:0], 8'h0F, {x[15:9], s[0]}, 1);
      run(`ALBX_OP_ONES, 0, 16'h00FF, 8'hFF, s, 1);
      for (j = 0; j < 6; j++)
      begin
        p = {{8{j % 3 != 0 && a[7]}}, a} * {{8{j % 3 == 1 && b[7]}}, b};
        w = j > 2 ? p << 1 : p;
        run(6'(`ALBX_OP_MUL_UU + j), 1, w, 8'h03, {6'h00, w == 16'h0000, p[15]}, 2);
      end
      run(`ALBX_OP_RGOTO, 2, rl, 8'hFF, s, 2);
      run(`ALBX_OP_IGOTO, 2, zp, 8'hFF, s, 2);
      run(`ALBX_OP_DGOTO, 2, tg, 8'hFF, s, 3);
      run(`ALBX_OP_RINVOKE, 2, rl, 8'hFF, s, 3);
      run(`ALBX_OP_IINVOKE, 2, zp, 8'hFF, s, 3);
      run(`ALBX_OP_DINVOKE, 2, tg, 8'hFF, s, 4);
      run(`ALBX_OP_SUB_BACK, 2, sp, 8'hFF, s, 4);
      run(`ALBX_OP_INT_BACK, 2, sp, 8'h7F, s, 4);
      for (j = 0; j < 5; j++)
      begin
        cd = j == 0 ? a == b : j == 1 ? !b[bs] : j == 2 ? b[bs] : j == 3 ? !io[bs] : io[bs];
        run(6'(`ALBX_OP_SKIP_EQ + j), 2, 16'(pc + (cd ? (tw ? 3 : 2) : 1)), 8'hFF, s, cd ? (tw ? 3 : 2) : 1);
      end
      for (j = 0; j < 4; j++)
      begin
        cd = j == 0 ? s[bs] : j == 1 ? !s[bs] : j == 2 ? s[2] == s[3] : s[2] != s[3];
        run(6'(`ALBX_OP_BR_SET + j), 2, cd ? rl : pc + 16'h0001, 8'hFF, s, cd ? 2 : 1);
      end
      // word constants are six bits wide
      k = k & 8'h3F;
      w = {h, a};
      for (j = 0; j < 2; j++)
      begin
        t = j ? {1'b0, w} - k : w + k;
        cd = j ? w[15] & !t[15] : !w[15] & t[15];
        run(6'(`ALBX_OP_WSUM + j), 1, t[15:0], 8'h1F, {3'h0, t[15] ^ cd, cd, t[15], t[15:0] == 16'h0000, t[16]}, 2);
      end
    end
    repeat (3) @(posedge clk_sys);
    conclude();
  end
endmodule
`default_nettype wire
